// file: rtl/apts_pkg.sv
// Package of constants and types for the ADC power-up and autotrim sequencer
package apts_pkg;
   localparam int unsigned CLK_FREQ_HZ       = 200_000_000;
   localparam int unsigned CLK_PERIOD_PS     = 5000;
   // Master clock figures are quoted for this rate
   localparam int unsigned MCLK_REF_HZ       = 4_000_000;
   // Wake-up time from full power-down, ns
   localparam int unsigned WAKE_TIME_NS      = 5000;
   localparam int unsigned WAKE_CYCLES       = (WAKE_TIME_NS * 1000 + CLK_PERIOD_PS - 1)
                                               / CLK_PERIOD_PS;
   // Durations given in ns or us, then converted to master clock periods at the quoted rate
   localparam int unsigned CONV_TIME_NS      = 4600;
   localparam int unsigned CONV_MCLK         = CONV_TIME_NS * (MCLK_REF_HZ / 1_000_000) / 1000;
   localparam int unsigned CAL_FULL_US       = 31250;
   localparam int unsigned CAL_GO_US         = 6940;
   localparam int unsigned CAL_ONE_US        = 3470;
   localparam int unsigned CAL_FULL_MCLK     = CAL_FULL_US * (MCLK_REF_HZ / 1_000_000);
   localparam int unsigned CAL_GO_MCLK       = CAL_GO_US * (MCLK_REF_HZ / 1_000_000);
   localparam int unsigned CAL_ONE_MCLK      = CAL_ONE_US * (MCLK_REF_HZ / 1_000_000);
   localparam int unsigned CNT_W             = 20;
   // Power select codes {hi, lo}
   localparam logic [1:0]  PSEL_SLEEP_CTRL   = 2'h0;
   localparam logic [1:0]  PSEL_NORMAL       = 2'h1;
   localparam logic [1:0]  PSEL_FULL_DOWN    = 2'h2;
   localparam logic [1:0]  PSEL_PARTIAL      = 2'h3;
   // Calibration type codes
   localparam logic [1:0]  CAL_FULL          = 2'h0;
   localparam logic [1:0]  CAL_GAIN_OFFSET   = 2'h1;
   localparam logic [1:0]  CAL_OFFSET        = 2'h2;
   localparam logic [1:0]  CAL_GAIN          = 2'h3;
   // Power state codes on the status port
   localparam logic [1:0]  PWR_ON            = 2'h0;
   localparam logic [1:0]  PWR_PARTIAL       = 2'h1;
   localparam logic [1:0]  PWR_FULL          = 2'h2;
   typedef enum logic [6:0] {
      ST_POWERON = 7'h01,
      ST_DOWN    = 7'h02,
      ST_WAKE    = 7'h04,
      ST_IDLE    = 7'h08,
      ST_CAL     = 7'h10,
      ST_CONV    = 7'h20,
      ST_PARTIAL = 7'h40
   } apts_state_t;
endpackage

// file: rtl/apts_mclk_timer.sv
// Down-counter of master clock periods, the time base for conversions and calibrations
`timescale 1ns/100ps
module apts_mclk_timer #(
   parameter int unsigned CNT_W = 20
) (
   input  wire logic             clock_i,
   input  wire logic             resetn_i,
   input  wire logic             mclk_tick_i,
   input  wire logic             load_i,
   input  wire logic [CNT_W-1:0] count_i,
   output logic                  done_o
);
   logic [CNT_W-1:0] cnt_reg;
   logic [CNT_W-1:0] cnt_next;
   logic             run_reg;
   logic             run_next;
   logic             done_reg;
   logic             done_next;

   always_comb
   begin
      cnt_next  = cnt_reg;
      run_next  = run_reg;
      done_next = 1'b0;
      if (load_i)
      begin
         cnt_next = count_i;
         run_next = 1'b1;
      end
      else if (run_reg && mclk_tick_i)
      begin
         if (cnt_reg <= 1)
         begin
            run_next  = 1'b0;
            done_next = 1'b1;
         end
         cnt_next = cnt_reg - 1'b1;
      end
   end

   always_ff @(posedge clock_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         cnt_reg  <= '0;
         run_reg  <= 1'b0;
         done_reg <= 1'b0;
      end
      else
      begin
         cnt_reg  <= cnt_next;
         run_reg  <= run_next;
         done_reg <= done_next;
      end
   end

   assign done_o = done_reg;
endmodule

// file: rtl/apts_sequencer.sv
// Power-up, power-down and autotrim sequencer of a sampling ADC
`timescale 1ns/100ps
module apts_sequencer
   import apts_pkg::*;
#(
   parameter int unsigned WAKE_CYC      = WAKE_CYCLES,
   parameter int unsigned CAL_FULL_CYC  = CAL_FULL_MCLK,
   parameter int unsigned CAL_GO_CYC    = CAL_GO_MCLK,
   parameter int unsigned CAL_ONE_CYC   = CAL_ONE_MCLK,
   parameter int unsigned CONV_CYC      = CONV_MCLK
) (
   input  wire logic       clock_i,
   input  wire logic       resetn_i,
   input  wire logic       master_clock_in_i,
   input  wire logic       trim_n_i,
   input  wire logic       sleep_n_i,
   input  wire logic       sample_start_pin_i,
   input  wire logic       reg_write_i,
   input  wire logic       power_select_hi_i,
   input  wire logic       power_select_lo_i,
   input  wire logic       trim_start_bit_i,
   input  wire logic [1:0] cal_type_i,
   input  wire logic       soft_convert_i,
   output logic            busy_o,
   output logic            ready_o,
   output logic [1:0]      power_state_o,
   output logic            reference_on_o,
   output logic            poweron_cal_done_o
);
   import apts_pkg::*;

   // Only the wake and full calibration lengths are checked against the counter width; a zero length would end after one tick, like a length of one
   if (WAKE_CYC < 1 || WAKE_CYC >= (1 << CNT_W) || CAL_FULL_CYC >= (1 << CNT_W)
       || CONV_CYC < 1 || CAL_ONE_CYC < 1 || CAL_GO_CYC < 1)
   begin : g_param_check
      $error("apts_sequencer: timing parameter out of counter range");
   end

   function automatic logic [CNT_W-1:0] cal_len(input logic [1:0] kind);
      case (kind)
         CAL_FULL:        cal_len = CNT_W'(CAL_FULL_CYC);
         CAL_GAIN_OFFSET: cal_len = CNT_W'(CAL_GO_CYC);
         default:         cal_len = CNT_W'(CAL_ONE_CYC);
      endcase
   endfunction

   apts_state_t      state_reg;
   apts_state_t      state_next;
   logic [1:0]       psel_reg;
   logic [1:0]       psel_next;
   logic [1:0]       caltype_reg;
   logic [1:0]       caltype_next;
   logic             pwron_reg;
   logic             pwron_next;
   logic             trim_q_reg;
   logic             start_q_reg;
   logic             mclk_q_reg;
   logic             first_reg;
   logic [CNT_W-1:0] wake_reg;
   logic [CNT_W-1:0] wake_next;
   logic             busy_reg;
   logic             busy_next;
   logic             ready_reg;
   logic             ready_next;
   logic [1:0]       pstate_reg;
   logic [1:0]       pstate_next;
   logic             refon_reg;
   logic             refon_next;
   logic             cal_pend_reg;
   logic             cal_pend_next;
   logic             tmr_load;
   logic [CNT_W-1:0] tmr_count;
   logic             tmr_done;
   logic             mclk_tick;
   logic             trim_rise;
   logic             start_fall;
   logic             start_rise;
   logic             want_down;
   logic             want_partial;
   logic             cal_req;

   assign mclk_tick  = master_clock_in_i & ~mclk_q_reg;
   assign trim_rise  = trim_n_i & ~trim_q_reg;
   assign start_fall = ~sample_start_pin_i & start_q_reg;
   assign start_rise = sample_start_pin_i & ~start_q_reg;
   // A request in the cycle that launches the pending one is kept, not lost
   assign cal_req    = (reg_write_i && trim_start_bit_i)
                       || (trim_rise && !first_reg && state_reg != ST_POWERON);

   always_comb
   begin
      want_down    = 1'b0;
      want_partial = 1'b0;
      case (psel_reg)
         PSEL_SLEEP_CTRL: want_down    = ~sleep_n_i;
         PSEL_NORMAL:     want_down    = 1'b0;
         PSEL_FULL_DOWN:  want_down    = 1'b1;
         PSEL_PARTIAL:    want_partial = 1'b1;
         default:         want_down    = 1'b0;
      endcase
   end

   // One timer serves calibration and conversion; the two never overlap
   apts_mclk_timer #(
      .CNT_W       (CNT_W)
   ) u_timer (
      .clock_i     (clock_i),
      .resetn_i    (resetn_i),
      .mclk_tick_i (mclk_tick),
      .load_i      (tmr_load),
      .count_i     (tmr_count),
      .done_o      (tmr_done)
   );

   always_comb
   begin
      state_next    = state_reg;
      psel_next     = psel_reg;
      caltype_next  = caltype_reg;
      pwron_next    = pwron_reg;
      wake_next     = wake_reg;
      cal_pend_next = cal_pend_reg;
      tmr_load      = 1'b0;
      tmr_count     = '0;
      if (reg_write_i)
      begin
         psel_next = {power_select_hi_i, power_select_lo_i};
         if (trim_start_bit_i)
         begin
            caltype_next  = cal_type_i;
            cal_pend_next = 1'b1;
         end
      end
      if (trim_rise && !first_reg && state_reg != ST_POWERON)
      begin
         caltype_next  = reg_write_i && trim_start_bit_i ? cal_type_i : caltype_reg;
         cal_pend_next = 1'b1;
      end
      case (state_reg)
         ST_POWERON:
         begin
            // Trim high at reset release skips calibration
            if (first_reg && trim_n_i)
            begin
               pwron_next = 1'b1;
               state_next = ST_IDLE;
            end
            else if (trim_rise)
            begin
               caltype_next = CAL_FULL;
               tmr_load     = 1'b1;
               tmr_count    = cal_len(CAL_FULL);
               state_next   = ST_CAL;
            end
         end
         ST_DOWN, ST_PARTIAL:
         begin
            // Wake on falling edge or on request
            if (start_fall || cal_pend_reg
                || (!want_down && (state_reg == ST_DOWN || !want_partial)))
            begin
               wake_next  = CNT_W'(WAKE_CYC);
               state_next = ST_WAKE;
            end
         end
         ST_WAKE:
         begin
            if (wake_reg <= 1)
               state_next = ST_IDLE;
            else
               wake_next = wake_reg - 1'b1;
         end
         ST_IDLE:
         begin
            if (cal_pend_reg)
            begin
               cal_pend_next = cal_req;
               tmr_load      = 1'b1;
               tmr_count     = cal_len(caltype_next);
               state_next    = ST_CAL;
            end
            else if (start_rise || soft_convert_i)
            begin
               tmr_load   = 1'b1;
               tmr_count  = CNT_W'(CONV_CYC);
               state_next = ST_CONV;
            end
            // Under sleep control, stay up while the start pin is low, awaiting its rise
            else if (want_down
                     && (sample_start_pin_i || psel_reg != PSEL_SLEEP_CTRL))
               state_next = ST_DOWN;
            else if (want_partial)
               state_next = ST_PARTIAL;
         end
         ST_CAL:
         begin
            // Return to idle or full down, never straight to partial
            if (tmr_done)
            begin
               pwron_next = 1'b1;
               state_next = want_down ? ST_DOWN : ST_IDLE;
               // Held partial code must be written again
               if (!reg_write_i && psel_reg == PSEL_PARTIAL)
                  psel_next = PSEL_NORMAL;
            end
         end
         ST_CONV:
         begin
            if (tmr_done)
               state_next = want_down ? ST_DOWN : (want_partial ? ST_PARTIAL : ST_IDLE);
         end
         default: state_next = ST_POWERON;
      endcase
   end

   // Outputs registered from the next state so they line up with it
   always_comb
   begin
      busy_next   = (state_next == ST_CAL) || (state_next == ST_CONV);
      ready_next  = (state_next == ST_IDLE);
      refon_next  = (state_next != ST_DOWN);
      pstate_next = PWR_ON;
      if (state_next == ST_DOWN)
         pstate_next = PWR_FULL;
      else if (state_next == ST_PARTIAL)
         pstate_next = PWR_PARTIAL;
   end

   always_ff @(posedge clock_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         state_reg    <= ST_POWERON;
         psel_reg     <= PSEL_SLEEP_CTRL;
         caltype_reg  <= CAL_FULL;
         pwron_reg    <= 1'b0;
         wake_reg     <= '0;
         cal_pend_reg <= 1'b0;
         trim_q_reg   <= 1'b0;
         start_q_reg  <= 1'b1;
         mclk_q_reg   <= 1'b0;
         first_reg    <= 1'b1;
         busy_reg     <= 1'b0;
         ready_reg    <= 1'b0;
         pstate_reg   <= PWR_ON;
         refon_reg    <= 1'b1;
      end
      else
      begin
         state_reg    <= state_next;
         psel_reg     <= psel_next;
         caltype_reg  <= caltype_next;
         pwron_reg    <= pwron_next;
         wake_reg     <= wake_next;
         cal_pend_reg <= cal_pend_next;
         trim_q_reg   <= trim_n_i;
         start_q_reg  <= sample_start_pin_i;
         mclk_q_reg   <= master_clock_in_i;
         first_reg    <= 1'b0;
         busy_reg     <= busy_next;
         ready_reg    <= ready_next;
         pstate_reg   <= pstate_next;
         refon_reg    <= refon_next;
      end
   end

   assign busy_o             = busy_reg;
   assign ready_o            = ready_reg;
   assign power_state_o      = pstate_reg;
   assign reference_on_o     = refon_reg;
   assign poweron_cal_done_o = pwron_reg;
endmodule

// file: verif/apts_sequencer_sva.sv
// Port-level checker of the power and trim sequencer
`timescale 1ns/100ps
module apts_sequencer_sva
   import apts_pkg::*;
#(
   parameter int unsigned WAKE_CYC = 4
) (
   input wire logic       clock_i,
   input wire logic       resetn_i,
   input wire logic       master_clock_in_i,
   input wire logic       trim_n_i,
   input wire logic       sleep_n_i,
   input wire logic       sample_start_pin_i,
   input wire logic       reg_write_i,
   input wire logic       power_select_hi_i,
   input wire logic       power_select_lo_i,
   input wire logic       trim_start_bit_i,
   input wire logic [1:0] cal_type_i,
   input wire logic       soft_convert_i,
   input wire logic       busy_o,
   input wire logic       ready_o,
   input wire logic [1:0] power_state_o,
   input wire logic       reference_on_o,
   input wire logic       poweron_cal_done_o
);
   localparam int WK_LO = WAKE_CYC - 1;
   localparam int WK_HI = WAKE_CYC + 2;
   logic [1:0] psel_reg;
   logic [1:0] psel_next;
   // Shadow of the power select bits, taken like the design takes them
   always_comb
   begin
      psel_next = reg_write_i ? {power_select_hi_i, power_select_lo_i} : psel_reg;
   end
   always_ff @(posedge clock_i or negedge resetn_i)
   begin
      if (!resetn_i)
         psel_reg <= 2'h0;
      else
         psel_reg <= psel_next;
   end
   default clocking @(posedge clock_i); endclocking
   default disable iff (!resetn_i);
   busy_idle_a: assert property (
      busy_o |-> !ready_o) else $error("busy and ready together");
   ref_state_a: assert property (
      reference_on_o == (power_state_o != PWR_FULL)) else $error("reference level wrong");
   sleep_ign_a: assert property (
      !poweron_cal_done_o |-> power_state_o == PWR_ON) else $error("down before cal end");
   skip_cal_a: assert property (
      $rose(resetn_i) && trim_n_i |=> poweron_cal_done_o) else $error("auto cal not skipped");
   conv_start_a: assert property (
      ($rose(sample_start_pin_i) || soft_convert_i) && ready_o |-> ##[1:2] busy_o)
      else $error("conversion not started");
   wake_pin_a: assert property (
      $fell(sample_start_pin_i) && power_state_o == PWR_FULL && !sleep_n_i
      && psel_reg == 2'h0 && poweron_cal_done_o
      |-> ##1 power_state_o == PWR_ON ##[WK_LO:WK_HI] ready_o) else $error("wake wrong");
   auto_down_a: assert property (
      $fell(busy_o) && psel_reg == 2'h0 && !sleep_n_i |-> power_state_o == PWR_FULL)
      else $error("no full down after busy");
   no_partial_a: assert property (
      $fell(busy_o) && psel_reg == 2'h1 |-> ready_o && power_state_o == PWR_ON)
      else $error("not idle after busy");
   full_down_a: assert property (
      reg_write_i && {power_select_hi_i, power_select_lo_i} == 2'h2 && ready_o
      |-> ##[1:3] power_state_o == PWR_FULL) else $error("full down not entered");
   cal_start_a: assert property (
      reg_write_i && trim_start_bit_i && ready_o |-> ##[1:3] busy_o)
      else $error("calibration not started");
endmodule
bind apts_sequencer apts_sequencer_sva #(.WAKE_CYC(WAKE_CYC)) u_sva (
   .clock_i            (clock_i),
   .resetn_i           (resetn_i),
   .master_clock_in_i  (master_clock_in_i),
   .trim_n_i           (trim_n_i),
   .sleep_n_i          (sleep_n_i),
   .sample_start_pin_i (sample_start_pin_i),
   .reg_write_i        (reg_write_i),
   .power_select_hi_i  (power_select_hi_i),
   .power_select_lo_i  (power_select_lo_i),
   .trim_start_bit_i   (trim_start_bit_i),
   .cal_type_i         (cal_type_i),
   .soft_convert_i     (soft_convert_i),
   .busy_o             (busy_o),
   .ready_o            (ready_o),
   .power_state_o      (power_state_o),
   .reference_on_o     (reference_on_o),
   .poweron_cal_done_o (poweron_cal_done_o)
);

// file: verif/apts_mclk_model.sv
// Free-running master clock source on the converter's clock pin
`timescale 1ns/100ps
module apts_mclk_model #(
   parameter int HALF = 2
) (
   input  wire logic clock_i,
   output logic      master_clock_o
);
   int   cnt = 0;
   logic mc  = 1'b0;
   // Tick source; a master clock runs free, also between frames
   always @(posedge clock_i)
   begin
      if (cnt >= HALF - 1)
      begin
         cnt <= 0;
         mc  <= ~mc;
      end
      else
         cnt <= cnt + 1;
   end
   assign master_clock_o = mc;
endmodule

// file: verif/apts_sequencer_tb.sv
// Self-checking bench of the power and trim sequencer
`timescale 1ns/100ps
`define CHK(a, b, m) begin samples_checked++; if ((a) !== (b)) begin failures++; \
   $display("BAD %0t %s", $time, m); end end
module apts_sequencer_tb;
   import apts_pkg::*;
   localparam int MP = 4;
   localparam int WK = 4;
   // Host power-up wait, scaled like the other timings
   localparam int PU = 60;
   logic       clock_i = 1'b0;
   logic       resetn_i;
   logic       master_clock_in_i;
   logic       trim_n_i;
   logic       sleep_n_i;
   logic       sample_start_pin_i;
   logic       reg_write_i;
   logic       power_select_hi_i;
   logic       power_select_lo_i;
   logic       trim_start_bit_i;
   logic [1:0] cal_type_i;
   logic       soft_convert_i;
   logic       busy_o;
   logic       ready_o;
   logic [1:0] power_state_o;
   logic       reference_on_o;
   logic       poweron_cal_done_o;
   int         failures = 0;
   int         samples_checked = 0;
   int         n;
   int         tk[4] = '{20, 10, 5, 5};
   always #2.5 clock_i = ~clock_i;
   apts_mclk_model #(.HALF(MP / 2)) u_mclk (.clock_i(clock_i), .master_clock_o(master_clock_in_i));
   apts_sequencer #(.WAKE_CYC(WK), .CAL_FULL_CYC(20), .CAL_GO_CYC(10), .CAL_ONE_CYC(5),
      .CONV_CYC(3)) DUT (
      .clock_i            (clock_i),
      .resetn_i           (resetn_i),
      .master_clock_in_i  (master_clock_in_i),
      .trim_n_i           (trim_n_i),
      .sleep_n_i          (sleep_n_i),
      .sample_start_pin_i (sample_start_pin_i),
      .reg_write_i        (reg_write_i),
      .power_select_hi_i  (power_select_hi_i),
      .power_select_lo_i  (power_select_lo_i),
      .trim_start_bit_i   (trim_start_bit_i),
      .cal_type_i         (cal_type_i),
      .soft_convert_i     (soft_convert_i),
      .busy_o             (busy_o),
      .ready_o            (ready_o),
      .power_state_o      (power_state_o),
      .reference_on_o     (reference_on_o),
      .poweron_cal_done_o (poweron_cal_done_o)
   );
   task automatic cyc(input int k);
      repeat (k) @(negedge clock_i);
   endtask
   // Waits on busy (w=0) or ready (w=1), bounded
   task automatic wt(input logic w, input logic v, input int lim, output int c);
      c = 0;
      while (((w ? ready_o : busy_o) !== v) && c < lim)
      begin
         cyc(1);
         c++;
      end
      if (c >= lim)
      begin
         failures++;
         $display("BAD %0t wait ran out", $time);
         final_report();
      end
   endtask
   task automatic wr(input logic [1:0] ps, input logic st, input logic [1:0] ct);
      {power_select_hi_i, power_select_lo_i} = ps;
      trim_start_bit_i = st;
      cal_type_i = ct;
      reg_write_i = 1'b1;
      cyc(1);
      reg_write_i = 1'b0;
   endtask
   // Busy length in master ticks; phase of the first tick is unknown
   task automatic busy_len(input int t);
      int c;
      wt(1'b0, 1'b1, 6, c);
      wt(1'b0, 1'b0, t * MP + 20, c);
      `CHK(c >= (t - 1) * MP && c <= t * MP + 4, 1'b1, "busy length")
   endtask
   task automatic final_report();
      $display("checked %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial
   begin
      resetn_i = 1'b0;
      trim_n_i = 1'b0;
      sleep_n_i = 1'b0;
      sample_start_pin_i = 1'b1;
      {reg_write_i, power_select_hi_i, power_select_lo_i} = 3'h0;
      {trim_start_bit_i, cal_type_i, soft_convert_i} = 4'h0;
      cyc(16);
      resetn_i = 1'b1;
      cyc(30);
      `CHK(power_state_o, PWR_ON, "slept early")
      `CHK(poweron_cal_done_o, 1'b0, "early done")
      trim_n_i = 1'b1;
      busy_len(20);
      cyc(1);
      `CHK(poweron_cal_done_o, 1'b1, "no done")
      `CHK(power_state_o, PWR_FULL, "no sleep")
      $display("power-on test ended");
      sample_start_pin_i = 1'b0;
      cyc(2);
      `CHK(power_state_o, PWR_ON, "no wake")
      wt(1'b1, 1'b1, 20, n);
      `CHK(n >= WK - 1 && n <= WK + 1, 1'b1, "wake time")
      cyc(2);
      `CHK(ready_o, 1'b1, "slept with pin low")
      sample_start_pin_i = 1'b1;
      busy_len(3);
      `CHK(power_state_o, PWR_FULL, "no auto down")
      $display("pin conversion test ended");
      resetn_i = 1'b0;
      sleep_n_i = 1'b1;
      cyc(3);
      resetn_i = 1'b1;
      cyc(2);
      `CHK(poweron_cal_done_o, 1'b1, "cal not skipped")
      `CHK(busy_o, 1'b0, "busy on skip")
      cyc(PU);
      wr(2'h1, 1'b0, 2'h0);
      wt(1'b1, 1'b1, 10, n);
      soft_convert_i = 1'b1;
      cyc(1);
      soft_convert_i = 1'b0;
      busy_len(3);
      for (int c = 3; c >= 0; c--)
      begin
         wr(2'h1, 1'b1, c[1:0]);
         busy_len(tk[c]);
         `CHK(ready_o, 1'b1, "not idle")
      end
      $display("calibration test ended");
      trim_n_i = 1'b0;
      cyc(2);
      trim_n_i = 1'b1;
      busy_len(20);
      sleep_n_i = 1'b0;
      cyc(3);
      `CHK(ready_o, 1'b1, "slept under 01")
      wr(2'h3, 1'b1, 2'h2);
      busy_len(5);
      cyc(3);
      `CHK(ready_o, 1'b1, "auto partial")
      wr(2'h3, 1'b0, 2'h0);
      cyc(2);
      `CHK(power_state_o, PWR_PARTIAL, "no partial")
      `CHK(reference_on_o, 1'b1, "ref off")
      wr(2'h1, 1'b0, 2'h0);
      wt(1'b1, 1'b1, 20, n);
      wr(2'h2, 1'b0, 2'h0);
      cyc(2);
      `CHK(power_state_o, PWR_FULL, "no full down")
      `CHK(reference_on_o, 1'b0, "ref on")
      wr(2'h1, 1'b0, 2'h0);
      wt(1'b1, 1'b1, 20, n);
      `CHK(n <= WK + 2, 1'b1, "slow wake")
      $display("power mode test ended");
      final_report();
   end
endmodule
